//--- led_bank_pkg.sv
// Shared constants, field layouts and state types for the LED driver register bank
`default_nettype none
package led_bank_pkg;

	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 8;
	localparam int NUM_CTRL = 37;
	localparam int IDX_W    = 6;

	// Register offsets
	localparam logic [7:0] OFF_STRING_ENABLE_LOW        = 8'h00;
	localparam logic [7:0] OFF_STRING_ENABLE_HIGH       = 8'h01;
	localparam logic [7:0] OFF_DEVICE_CONFIGURATION     = 8'h02;
	localparam logic [7:0] OFF_FAULT_TYPE_ENABLE        = 8'h03;
	localparam logic [7:0] OFF_STRING_FAULT_MASK_LOW    = 8'h04;
	localparam logic [7:0] OFF_STRING_FAULT_MASK_HIGH   = 8'h05;
	localparam logic [7:0] OFF_FAULT_SUMMARY_STATUS     = 8'h06;
	localparam logic [7:0] OFF_OPEN_CIRCUIT_STATUS_LOW  = 8'h07;
	localparam logic [7:0] OFF_OPEN_CIRCUIT_STATUS_HIGH = 8'h08;
	localparam logic [7:0] OFF_SHORT_CIRCUIT_STATUS_LOW = 8'h09;
	localparam logic [7:0] OFF_SHORT_CIRCUIT_STATUS_HIGH = 8'h0a;
	localparam logic [7:0] OFF_UNUSED_A_FIRST           = 8'h0b;
	localparam logic [7:0] OFF_UNUSED_A_LAST            = 8'h0e;
	localparam logic [7:0] OFF_OSCILLATOR_FREQUENCY_SELECT = 8'h0f;
	localparam logic [7:0] OFF_OPTIMIZER_CONTROL_A      = 8'h10;
	localparam logic [7:0] OFF_OPTIMIZER_CONTROL_B      = 8'h11;
	localparam logic [7:0] OFF_OPTIMIZER_CONTROL_C      = 8'h12;
	localparam logic [7:0] OFF_OPTIMIZER_DAC_READBACK_1 = 8'h13;
	localparam logic [7:0] OFF_OPTIMIZER_DAC_READBACK_2 = 8'h14;
	localparam logic [7:0] OFF_OPTIMIZER_DAC_READBACK_3 = 8'h15;
	localparam logic [7:0] OFF_OPTIMIZER_STATUS         = 8'h16;
	localparam logic [7:0] OFF_UNUSED_B_FIRST           = 8'h17;
	localparam logic [7:0] OFF_UNUSED_B_LAST            = 8'h1f;
	localparam logic [7:0] OFF_LINE_CLOCK_PROCESSING_CONTROL = 8'h20;
	localparam logic [7:0] OFF_LINE_CLOCK_INTERNAL_COUNTER_LO = 8'h21;
	localparam logic [7:0] OFF_LINE_CLOCK_INTERNAL_COUNTER_HI = 8'h22;
	localparam logic [7:0] OFF_LINE_CLOCK_MULTIPLIER    = 8'h23;
	localparam logic [7:0] OFF_LINE_CLOCK_DIVIDER       = 8'h24;
	localparam logic [7:0] OFF_CTRL_LAST                = 8'hbf;
	localparam logic [7:0] OFF_NVM_ADDRESS              = 8'hc0;
	localparam logic [7:0] OFF_NVM_DATA                 = 8'hc1;

	// Implemented bits; reserved bits read as zero
	localparam logic [7:0] MASK_FULL            = 8'hff;
	localparam logic [7:0] MASK_CONFIG          = 8'h8f;
	localparam logic [7:0] MASK_FAULT_ENABLE    = 8'h3f;
	localparam logic [7:0] MASK_FAULT_SUMMARY   = 8'h9f;
	localparam logic [7:0] MASK_OSC_FREQ        = 8'h07;
	localparam logic [7:0] MASK_OPT_CONTROL_C   = 8'h0f;
	localparam logic [7:0] MASK_LINE_CLOCK_CTRL = 8'h8f;
	localparam logic [7:0] MASK_LINE_CLOCK_MUL  = 8'h1f;

	// Field positions
	localparam int CONFIG_SLEEP_BIT    = 7;
	localparam int OPT_ENABLE_BIT      = 0;

	localparam logic [IDX_W-1:0] BOOT_LAST_IDX = 6'h24;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BOOT = 3'b010,
		ST_RUN  = 3'b100
	} boot_state_t;

	typedef logic [NUM_CTRL-1:0][DATA_W-1:0] ctrl_image_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0]  fault_summary_flags;
		logic [15:0] open_fault_flags;
		logic [15:0] short_fault_flags;
		logic [7:0]  optimizer_dac_1;
		logic [7:0]  optimizer_dac_2;
		logic [7:0]  optimizer_dac_3;
		logic [7:0]  optimizer_status;
	} status_in_t;

	typedef struct packed {
		boot_state_t       st;
		logic [IDX_W-1:0]  idx;
		ctrl_image_t       ctrl;
		logic [7:0]        fault_sum;
		logic [15:0]       open_flt;
		logic [15:0]       short_flt;
		logic [IDX_W-1:0]  nvm_addr;
		logic [DATA_W-1:0] rdata;
		logic              rvalid;
		logic [15:0]       strings_on;
		logic              opt_en;
		logic              busy;
	} bank_state_t;

	function automatic logic [7:0] write_mask(input logic [7:0] a);
		unique case (a)
			OFF_DEVICE_CONFIGURATION:          write_mask = MASK_CONFIG;
			OFF_FAULT_TYPE_ENABLE:             write_mask = MASK_FAULT_ENABLE;
			OFF_OSCILLATOR_FREQUENCY_SELECT:   write_mask = MASK_OSC_FREQ;
			OFF_OPTIMIZER_CONTROL_C:           write_mask = MASK_OPT_CONTROL_C;
			OFF_LINE_CLOCK_PROCESSING_CONTROL: write_mask = MASK_LINE_CLOCK_CTRL;
			OFF_LINE_CLOCK_MULTIPLIER:         write_mask = MASK_LINE_CLOCK_MUL;
			default:                           write_mask = MASK_FULL;
		endcase
	endfunction : write_mask

	function automatic logic is_writable(input logic [7:0] a);
		is_writable = (a <= OFF_FAULT_TYPE_ENABLE + 8'h02 && a < OFF_FAULT_SUMMARY_STATUS)
			|| (a >= OFF_OSCILLATOR_FREQUENCY_SELECT && a <= OFF_OPTIMIZER_CONTROL_C)
			|| (a >= OFF_LINE_CLOCK_PROCESSING_CONTROL && a <= OFF_LINE_CLOCK_DIVIDER);
	endfunction : is_writable

endpackage : led_bank_pkg
`default_nettype wire

//--- enable_sync.sv
// Two-stage synchroniser for the enable pin with a rising-edge pulse
`timescale 1ns/1ns
`default_nettype none
module enable_sync
	import led_bank_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      rise
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	always_comb begin
		s_d    = s_q;
		s_d.s1 = pin;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.s2;
	assign rise  = s_q.s2 & ~s_q.s3;

endmodule : enable_sync
`default_nettype wire

//--- nvm_store.sv
// Nonvolatile default store: one byte per control register, two read ports
`timescale 1ns/1ns
`default_nettype none
module nvm_store
	import led_bank_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              wr_en,
	input  wire logic [IDX_W-1:0]  wr_idx,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [IDX_W-1:0]  rd_a_idx,
	output logic      [DATA_W-1:0] rd_a_data,
	input  wire logic [IDX_W-1:0]  rd_b_idx,
	output logic      [DATA_W-1:0] rd_b_data
);

	// Contents survive reset, as the cells would survive power loss
	ctrl_image_t mem_q;
	ctrl_image_t mem_d;

	always_comb begin
		mem_d = mem_q;
		if (wr_en && wr_idx <= BOOT_LAST_IDX) begin
			mem_d[wr_idx] = wr_data;
		end
	end

	always_ff @(posedge clk) begin
		mem_q <= mem_d;
	end

	assign rd_a_data = (rd_a_idx <= BOOT_LAST_IDX) ? mem_q[rd_a_idx] : 8'h00;
	assign rd_b_data = (rd_b_idx <= BOOT_LAST_IDX) ? mem_q[rd_b_idx] : 8'h00;

endmodule : nvm_store
`default_nettype wire

//--- led_driver_register_bank.sv
// Control register bank of a 16-string LED driver with nonvolatile defaults
// Operation
// - Control registers decoded at 0x00 through 0x24
// - Registers 0xC0/0xC1 read and program nonvolatile store
// - Power-up defaults come from nonvolatile copy
// - Host may rewrite any stored default value
// - Enable rise boots defaults, clears fault bits
// - Enable low: ignore host, optimizer off, strings off
`timescale 1ns/1ns
`default_nettype none
module led_driver_register_bank
	import led_bank_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        en_pin,
	input  wire reg_req_t    req,
	input  wire status_in_t  status_in,
	output logic [7:0]       rdata_q,
	output logic             rvalid_q,
	output ctrl_image_t      ctrl_image_q,
	output logic [15:0]      strings_on_q,
	output logic             optimizer_enable_q,
	output logic             boot_busy_q
);

	bank_state_t s_q;
	bank_state_t s_d;

	logic              en_level;
	logic              en_rise;
	logic [DATA_W-1:0] boot_byte;
	logic [DATA_W-1:0] host_nvm_byte;
	logic              nvm_wr;
	logic              host_ok;
	logic              req_in_ctrl;
	logic              req_in_unused;
	logic [IDX_W-1:0]  req_idx;
	logic [7:0]        rd_value;
	logic [7:0]        sum_set;

	enable_sync u_enable_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   (en_pin),
		.level (en_level),
		.rise  (en_rise)
	);

	nvm_store u_nvm_store (
		.clk       (clk),
		.wr_en     (nvm_wr),
		.wr_idx    (s_q.nvm_addr),
		.wr_data   (req.wdata),
		.rd_a_idx  (s_q.idx),
		.rd_a_data (boot_byte),
		.rd_b_idx  (s_q.nvm_addr),
		.rd_b_data (host_nvm_byte)
	);

	// Host traffic counts only once the device is up and the boot copy is done
	assign host_ok       = en_level && (s_q.st == ST_RUN);
	assign req_in_ctrl   = (req.addr <= OFF_LINE_CLOCK_DIVIDER);
	assign req_idx       = req.addr[IDX_W-1:0];
	assign req_in_unused = (req.addr >= OFF_UNUSED_A_FIRST && req.addr <= OFF_UNUSED_A_LAST)
		|| (req.addr >= OFF_UNUSED_B_FIRST && req.addr <= OFF_UNUSED_B_LAST);
	assign nvm_wr        = host_ok && req.wr && req.addr == OFF_NVM_DATA;
	assign sum_set       = status_in.fault_summary_flags & MASK_FAULT_SUMMARY;

	// Read multiplexer
	always_comb begin
		rd_value = 8'h00;
		if (req_in_unused) begin
			rd_value = 8'h00;
		end else if (req.addr == OFF_FAULT_SUMMARY_STATUS) begin
			rd_value = s_q.fault_sum;
		end else if (req.addr == OFF_OPEN_CIRCUIT_STATUS_LOW) begin
			rd_value = s_q.open_flt[7:0];
		end else if (req.addr == OFF_OPEN_CIRCUIT_STATUS_HIGH) begin
			rd_value = s_q.open_flt[15:8];
		end else if (req.addr == OFF_SHORT_CIRCUIT_STATUS_LOW) begin
			rd_value = s_q.short_flt[7:0];
		end else if (req.addr == OFF_SHORT_CIRCUIT_STATUS_HIGH) begin
			rd_value = s_q.short_flt[15:8];
		end else if (req.addr == OFF_OPTIMIZER_DAC_READBACK_1) begin
			rd_value = status_in.optimizer_dac_1;
		end else if (req.addr == OFF_OPTIMIZER_DAC_READBACK_2) begin
			rd_value = status_in.optimizer_dac_2;
		end else if (req.addr == OFF_OPTIMIZER_DAC_READBACK_3) begin
			rd_value = status_in.optimizer_dac_3;
		end else if (req.addr == OFF_OPTIMIZER_STATUS) begin
			rd_value = status_in.optimizer_status;
		end else if (req_in_ctrl) begin
			rd_value = s_q.ctrl[req_idx] & write_mask(req.addr);
		end else if (req.addr == OFF_NVM_ADDRESS) begin
			rd_value = {2'b00, s_q.nvm_addr};
		end else if (req.addr == OFF_NVM_DATA) begin
			rd_value = host_nvm_byte;
		end
	end

	// Next-state logic
	always_comb begin
		s_d        = s_q;
		s_d.rvalid = 1'b0;

		// Fault flags are sticky; a new fault beats a boot clear in the same cycle
		s_d.fault_sum = s_q.fault_sum | sum_set;
		s_d.open_flt  = s_q.open_flt | status_in.open_fault_flags;
		s_d.short_flt = s_q.short_flt | status_in.short_fault_flags;

		unique case (s_q.st)
			ST_IDLE: begin
				s_d.idx = '0;
				if (en_rise) begin
					s_d.st   = ST_BOOT;
					s_d.busy = 1'b1;
				end
			end
			ST_BOOT: begin
				s_d.ctrl[s_q.idx] = boot_byte & write_mask({2'b00, s_q.idx});
				if (s_q.idx == BOOT_LAST_IDX) begin
					s_d.st   = ST_RUN;
					s_d.busy = 1'b0;
					s_d.idx  = '0;
				end else begin
					s_d.idx = s_q.idx + 6'h01;
				end
			end
			ST_RUN: begin
				if (req.wr && host_ok) begin
					if (req_in_ctrl && !req_in_unused && is_writable(req.addr)) begin
						s_d.ctrl[req_idx] = req.wdata & write_mask(req.addr);
					end else if (req.addr == OFF_NVM_ADDRESS) begin
						s_d.nvm_addr = req.wdata[IDX_W-1:0];
					end
				end
				if (req.rd && host_ok) begin
					s_d.rdata  = rd_value;
					s_d.rvalid = 1'b1;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		// Boot clears the fault registers; pending fault inputs still land
		if (en_rise) begin
			s_d.fault_sum = sum_set;
			s_d.open_flt  = status_in.open_fault_flags;
			s_d.short_flt = status_in.short_fault_flags;
			s_d.st        = ST_BOOT;
			s_d.idx       = '0;
			s_d.busy      = 1'b1;
		end

		// Device disabled: drop to idle and wait for the next enable rise
		if (!en_level) begin
			s_d.st     = ST_IDLE;
			s_d.busy   = 1'b0;
			s_d.rvalid = 1'b0;
		end

		// Drive outputs follow control registers only while the device runs
		if (en_level && s_q.st == ST_RUN && !s_q.ctrl[OFF_DEVICE_CONFIGURATION][CONFIG_SLEEP_BIT]) begin
			s_d.strings_on = {s_q.ctrl[OFF_STRING_ENABLE_HIGH], s_q.ctrl[OFF_STRING_ENABLE_LOW]};
			s_d.opt_en     = s_q.ctrl[OFF_OPTIMIZER_CONTROL_C][OPT_ENABLE_BIT];
		end else begin
			s_d.strings_on = 16'h0000;
			s_d.opt_en     = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q    <= '0;
			s_q.st <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_q            = s_q.rdata;
	assign rvalid_q           = s_q.rvalid;
	assign ctrl_image_q       = s_q.ctrl;
	assign strings_on_q       = s_q.strings_on;
	assign optimizer_enable_q = s_q.opt_en;
	assign boot_busy_q        = s_q.busy;

endmodule : led_driver_register_bank
`default_nettype wire

//--- fault_source.sv
// Host-side event source feeding the bank status inputs
`timescale 1ns/1ns
`default_nettype none
module fault_source
	import led_bank_pkg::*;
(
	input  wire logic open_evt,
	output var  status_in_t status
);
	// Open event on string 3 only while asked; live readbacks fixed
	assign status = '{fault_summary_flags: 8'h00, open_fault_flags: open_evt ? 16'h0008 : 16'h0000,
		short_fault_flags: 16'h0000, optimizer_dac_1: 8'h11, optimizer_dac_2: 8'h22,
		optimizer_dac_3: 8'h33, optimizer_status: 8'h00};
endmodule : fault_source
`default_nettype wire

//--- led_bank_asserts.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
`default_nettype none
module led_bank_asserts
	import led_bank_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        en_pin,
	input wire reg_req_t    req,
	input wire status_in_t  status_in,
	input wire logic [7:0]  rdata_q,
	input wire logic        rvalid_q,
	input wire ctrl_image_t ctrl_image_q,
	input wire logic [15:0] strings_on_q,
	input wire logic        optimizer_enable_q,
	input wire logic        boot_busy_q
);
	logic [7:0] busy_cnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk) begin
		if (rst || !boot_busy_q) begin
			busy_cnt_q <= 8'h00;
		end else begin
			busy_cnt_q <= busy_cnt_q + 8'h01;
		end
	end
	read_answer_a: assert property (rvalid_q |-> $past(req.rd)) else $error("answer without read");
	write_take_a: assert property (rvalid_q && $past(req.wr) && $past(req.addr) == 8'h00
		|-> ctrl_image_q[0] == $past(req.wdata)) else $error("write to 0x00 lost");
	boot_length_a: assert property ($fell(boot_busy_q) |-> busy_cnt_q == 8'h25) else $error("boot length");
	off_outputs_a: assert property ((!en_pin)[*4] |-> strings_on_q == 16'h0000 && !optimizer_enable_q)
		else $error("outputs on while disabled");
	off_ignore_a: assert property ((!en_pin)[*4] ##0 req.rd |=> !rvalid_q) else $error("read while off");
	boot_ignore_a: assert property (boot_busy_q && req.rd |=> !rvalid_q) else $error("read in boot");
	unused_zero_a: assert property (req.rd && (req.addr inside {[8'h0b:8'h0e], [8'h17:8'h1f]})
		|=> !rvalid_q || rdata_q == 8'h00) else $error("unused read nonzero");
	unused_write_a: assert property (req.wr && (req.addr inside {[8'h0b:8'h0e], [8'h17:8'h1f]})
		&& !boot_busy_q && $stable(en_pin) |=> $stable(ctrl_image_q)) else $error("unused write took");
	cover property ($fell(boot_busy_q));
	cover property (rvalid_q && rdata_q != 8'h00);
	cover property (req.wr && req.addr == 8'hc1);
endmodule : led_bank_asserts
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the LED driver register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import led_bank_pkg::*;
();
	logic        clk;
	logic        rst;
	logic        en_pin;
	reg_req_t    req;
	status_in_t  status_in;
	logic        open_evt;
	logic [7:0]  rdata_q;
	logic        rvalid_q;
	ctrl_image_t ctrl_image_q;
	logic [15:0] strings_on_q;
	logic        optimizer_enable_q;
	logic        boot_busy_q;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic [7:0]  nvm_idx [4] = '{8'h00, 8'h01, 8'h02, 8'h12};
	logic [7:0]  nvm_val [4] = '{8'h3c, 8'h00, 8'h00, 8'h01};
	logic [7:0]  unused_a [5] = '{8'h0b, 8'h0e, 8'h17, 8'h1f, 8'h30};

	led_driver_register_bank i_dut (.clk(clk), .rst(rst), .en_pin(en_pin), .req(req), .status_in(status_in),
		.rdata_q(rdata_q), .rvalid_q(rvalid_q), .ctrl_image_q(ctrl_image_q), .strings_on_q(strings_on_q),
		.optimizer_enable_q(optimizer_enable_q), .boot_busy_q(boot_busy_q));
	fault_source i_src (.open_evt(open_evt), .status(status_in));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic v);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1;
		chk(rvalid_q, v);
		if (v) chk(rdata_q, e);
	endtask : rd
	task automatic boot();
		@(posedge clk);
		en_pin <= 1'b1;
		repeat (6) @(posedge clk);
		rd(8'h00, 8'h00, 1'b0);
		repeat (36) @(posedge clk);
		#1;
		chk(boot_busy_q, 1'b0);
	endtask : boot
	task automatic report_and_stop();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t timeout", $time);
			report_and_stop();
		end
	end
	initial begin
		rst = 1'b1;
		en_pin = 1'b0;
		req = '0;
		open_evt = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		boot();
		for (int i = 0; i < 4; i++) begin
			wr(OFF_NVM_ADDRESS, nvm_idx[i]);
			wr(OFF_NVM_DATA, nvm_val[i]);
			rd(OFF_NVM_DATA, nvm_val[i], 1'b1);
		end
		wr(8'h00, 8'ha5);
		rd(8'h00, 8'ha5, 1'b1);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b1, addr: 8'h00, wdata: 8'h5a};
		@(posedge clk);
		req <= '0;
		#1;
		chk(rdata_q, 8'ha5);
		rd(8'h00, 8'h5a, 1'b1);
		for (int i = 0; i < 5; i++) begin
			wr(unused_a[i], 8'hff);
			rd(unused_a[i], 8'h00, 1'b1);
		end
		wr(8'h13, 8'hff);
		rd(8'h13, 8'h11, 1'b1);
		wr(8'h02, 8'hff);
		rd(8'h02, MASK_CONFIG, 1'b1);
		wr(8'h02, 8'h00);
		wr(8'h12, 8'h01);
		@(posedge clk);
		open_evt <= 1'b1;
		@(posedge clk);
		open_evt <= 1'b0;
		rd(8'h07, 8'h08, 1'b1);
		// Optimizer must be on before the disable check means anything
		chk(optimizer_enable_q, 1'b1);
		@(posedge clk);
		en_pin <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk(strings_on_q, 16'h0000);
		chk(optimizer_enable_q, 1'b0);
		rd(8'h00, 8'h00, 1'b0);
		boot();
		repeat (2) @(posedge clk);
		#1;
		chk(strings_on_q, 16'h003c);
		chk(optimizer_enable_q, 1'b1);
		rd(8'h00, 8'h3c, 1'b1);
		rd(8'h07, 8'h00, 1'b1);
		rd(8'h02, 8'h00, 1'b1);
		report_and_stop();
	end
endmodule : tb_top

bind led_driver_register_bank led_bank_asserts i_chk (.clk(clk), .rst(rst), .en_pin(en_pin), .req(req),
	.status_in(status_in), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .ctrl_image_q(ctrl_image_q),
	.strings_on_q(strings_on_q), .optimizer_enable_q(optimizer_enable_q), .boot_busy_q(boot_busy_q));
`default_nettype wire
